/* verilog/mmb_pkg.sv */
package mmb_pkg;

    // ------------------------------------------------------------
    // program space
    // ------------------------------------------------------------
    localparam int PC_W = 13;                      // full counter width
    localparam int PROG_IMPL_W = 11;               // implemented words: 2K
    localparam logic [12:0] RESET_VEC = 13'h0000;  // start after reset
    localparam logic [12:0] INT_VEC = 13'h0004;    // interrupt entry

    // ------------------------------------------------------------
    // data space
    // ------------------------------------------------------------
    localparam int DADDR_W = 9;                    // bank bits + 7-bit offset
    localparam int OFS_W = 7;                      // offset inside a bank
    localparam logic [6:0] INDF_OFS = 7'h00;       // indirect location
    localparam logic [6:0] PCL_OFS = 7'h02;        // low byte of counter
    localparam logic [6:0] STATUS_OFS = 7'h03;     // processor state
    localparam logic [6:0] PTR_OFS = 7'h04;        // indirect pointer
    localparam logic [6:0] PCLATH_OFS = 7'h0a;     // counter high latch
    localparam logic [6:0] GPR_LO = 7'h20;         // first ram offset
    localparam logic [6:0] SHARED_LO = 7'h70;      // ram seen in all banks
    localparam int BANK_HI_BIT = 6;                // bank_sel_hi position
    localparam int BANK_LO_BIT = 5;                // bank_sel_lo position
    localparam logic [7:0] STATUS_RST = 8'h18;     // state after reset
    localparam logic [7:0] PTR_RST = 8'h00;        // pointer after reset
    localparam logic [4:0] PCLATH_RST = 5'h00;     // latch after reset
    localparam int RAM_WORDS = 128;                // physical ram bytes

    // data access request from the core
    typedef struct packed {
        logic rd;            // read strobe
        logic wr;            // write strobe
        logic [6:0] f_addr;  // address field of the instruction
        logic [7:0] wdata;   // write data
    } mmb_dreq_s;

    // program flow request from the core
    typedef struct packed {
        logic step;          // advance to next word
        logic jump;          // load from jump target
        logic irq;           // take interrupt
        logic [10:0] target; // jump target bits
    } mmb_preq_s;

    // bank select encoding
    typedef enum logic [1:0] {
        MMB_BANK0 = 2'b00,
        MMB_BANK1 = 2'b01,
        MMB_BANK2 = 2'b10,
        MMB_BANK3 = 2'b11
    } mmb_bank_e;

endpackage : mmb_pkg

/* verilog/mmb_decode.sv */
`timescale 1ns/1ps
// combinational address decode for one data access
module mmb_decode
(
    // inputs
    input wire logic [1:0] bank_sel_field,
    input wire logic [6:0] f_addr,
    input wire logic [7:0] indirect_pointer,
    input wire logic irp,
    // outputs
    output logic [8:0] eff_addr,
    output logic is_sfr,
    output logic is_ram,
    output logic [6:0] ram_idx
);
    import mmb_pkg::*;

    // ------------------------------------------------------------
    // effective address
    // ------------------------------------------------------------
    always_comb begin
        // offset zero goes through the pointer; others join bank bits
        if (f_addr == INDF_OFS) begin
            eff_addr = {irp, indirect_pointer};
        end else begin
            eff_addr = {bank_sel_field, f_addr};
        end
    end

    // ------------------------------------------------------------
    // region split
    // ------------------------------------------------------------
    always_comb begin
        is_sfr = (eff_addr[6:0] < GPR_LO);
        is_ram = 1'b0;
        ram_idx = 7'h00;
        if (eff_addr[6:0] >= SHARED_LO) begin
            // top 16 bytes mirrored in every bank
            is_ram = 1'b1;
            // top slots of the array, so banked bytes never land here
            ram_idx = {3'b111, eff_addr[3:0]};
        end else if (eff_addr[6:0] >= GPR_LO) begin
            // bank 0 holds 80 bytes; bank 1 holds 32; banks 2/3 alias
            unique case (eff_addr[8:7])
                2'b00, 2'b10: begin
                    is_ram = 1'b1;
                    ram_idx = eff_addr[6:0] - GPR_LO;
                end
                default: begin
                    is_ram = (eff_addr[6:0] < 7'h40);
                    ram_idx = eff_addr[6:0] + 7'h30;
                end
            endcase
        end
    end

endmodule : mmb_decode

/* verilog/mmb_top.sv */
`timescale 1ns/1ps
// How it works
// - program counter thirteen bits wide, 8K space
// - fetches above 2K wrap onto implemented words
// - reset loads counter with address zero
// - interrupt sends flow to address four
// - status bits six/five select the bank
// - each bank spans 128 byte locations
// - low offsets are special registers, rest ram except the holes in odd banks
// - shared registers answer in every bank
// - direct address or pointer register both reach file
// - fetch and data ports run concurrently
// - unimplemented data locations read zero
// - offset zero acts through the pointer
module mmb_top
#(
    parameter int PROG_W = mmb_pkg::PROG_IMPL_W
)(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // program flow requests
    input wire mmb_pkg::mmb_preq_s preq,
    // data requests
    input wire mmb_pkg::mmb_dreq_s dreq,
    // program fetch port
    output logic [12:0] pc_out,
    output logic [10:0] fetch_addr,
    // data answer
    output logic [7:0] rdata,
    output logic rvalid,
    // bank state
    output logic [1:0] bank_sel_field
);
    import mmb_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (PROG_W < 3 || PROG_W > PC_W) begin : g_bad_prog_w
        $error("program width out of range");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [12:0] pc_r;              // program counter
    logic [12:0] pc_nxt;            // next counter value
    logic [7:0] status_r;           // processor state byte
    logic [7:0] ptr_r;              // indirect pointer register
    logic [4:0] pclath_r;           // high counter latch
    logic [7:0] ram [RAM_WORDS];    // general purpose bytes
    logic [8:0] eff_addr;           // decoded data address
    logic is_sfr;                   // special register region
    logic is_ram;                   // backed by ram
    logic [6:0] ram_idx;            // ram word index
    logic [7:0] rd_val;             // read mux result
    logic [7:0] ram_q;              // ram read word

    // bank bits straight out of the state byte
    wire logic [1:0] bank_now = {status_r[BANK_HI_BIT], status_r[BANK_LO_BIT]};

    // ------------------------------------------------------------
    // data decode
    // ------------------------------------------------------------
    mmb_decode u_dec (
        .bank_sel_field(bank_now),
        .f_addr(dreq.f_addr),
        .indirect_pointer(ptr_r),
        .irp(status_r[7]),
        .eff_addr(eff_addr),
        .is_sfr(is_sfr),
        .is_ram(is_ram),
        .ram_idx(ram_idx)
    );

    // a write that lands on a given special register offset
    function automatic logic sfr_hit(input logic [8:0] a, input logic [6:0] ofs);
        sfr_hit = (a[6:0] == ofs);
    endfunction : sfr_hit

    // ------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------
    always_comb begin
        // interrupt has priority over jump and step
        pc_nxt = pc_r;
        if (preq.irq) begin
            pc_nxt = INT_VEC;
        end else if (dreq.wr && sfr_hit(eff_addr, PCL_OFS)) begin
            pc_nxt = {pclath_r, dreq.wdata};
        end else if (preq.jump) begin
            pc_nxt = {pclath_r[4:3], preq.target};
        end else if (preq.step) begin
            pc_nxt = pc_r + 13'h0001;
        end
    end

    // counter register, cleared straight to the reset word
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc_r <= RESET_VEC;
        end else begin
            pc_r <= pc_nxt;
        end
    end

    // fetch port: upper bits dropped so high addresses wrap
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fetch_addr <= RESET_VEC[10:0];
            pc_out <= RESET_VEC;
        end else begin
            fetch_addr <= 11'(pc_nxt[PROG_W-1:0]);
            pc_out <= pc_nxt;
        end
    end

    // ------------------------------------------------------------
    // special register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_r <= STATUS_RST;
            ptr_r <= PTR_RST;
            pclath_r <= PCLATH_RST;
        end else if (dreq.wr && is_sfr) begin
            // these three are mirrored in all four banks
            if (sfr_hit(eff_addr, STATUS_OFS)) begin
                status_r <= dreq.wdata;
            end
            if (sfr_hit(eff_addr, PTR_OFS)) begin
                ptr_r <= dreq.wdata;
            end
            if (sfr_hit(eff_addr, PCLATH_OFS)) begin
                pclath_r <= dreq.wdata[4:0];
            end
        end
    end

    // ------------------------------------------------------------
    // general purpose ram
    // ------------------------------------------------------------
    // no reset: contents are undefined after power up, as on silicon
    always_ff @(posedge clk) begin
        if (dreq.wr && is_ram) begin
            ram[ram_idx] <= dreq.wdata;
        end
    end

    assign ram_q = ram[ram_idx];

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // ram wins over special registers; anything else reads zero
    always_comb begin
        rd_val = 8'h00;
        if (is_ram) begin
            rd_val = ram_q;
        end else if (is_sfr) begin
            // offset zero via pointer reaching offset zero reads zero
            unique case (eff_addr[6:0])
                PCL_OFS: rd_val = pc_r[7:0];
                STATUS_OFS: rd_val = status_r;
                PTR_OFS: rd_val = ptr_r;
                PCLATH_OFS: rd_val = {3'b000, pclath_r};
                default: rd_val = 8'h00;
            endcase
        end
    end

    // read answer one cycle later, forced to zero between reads
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rdata <= dreq.rd ? rd_val : 8'h00;
            rvalid <= dreq.rd;
        end
    end

    // bank copy follows every state write in the same edge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bank_sel_field <= 2'b00;
        end else if (dreq.wr && is_sfr && sfr_hit(eff_addr, STATUS_OFS)) begin
            bank_sel_field <= {dreq.wdata[BANK_HI_BIT], dreq.wdata[BANK_LO_BIT]};
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_reset_vector: assert property (@(posedge clk)
        $fell(sys_rst) |-> pc_r == RESET_VEC)
        else $error("counter not zero after reset");

    a_irq_vector: assert property (@(posedge clk) disable iff (sys_rst)
        preq.irq |=> pc_r == INT_VEC && fetch_addr == 11'h004)
        else $error("interrupt did not vector to four");

    a_fetch_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> fetch_addr == pc_r[10:0])
        else $error("fetch address does not wrap");

    a_pc_step: assert property (@(posedge clk) disable iff (sys_rst)
        preq.step && !preq.irq && !preq.jump && !dreq.wr |=> pc_r == $past(pc_r) + 13'h0001)
        else $error("counter did not step");

    a_bank_mirror: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> bank_sel_field == {status_r[6], status_r[5]})
        else $error("bank output disagrees with state");

    a_indirect_ptr: assert property (@(posedge clk) disable iff (sys_rst)
        dreq.f_addr == INDF_OFS |-> eff_addr[7:0] == ptr_r)
        else $error("indirect access ignored pointer");

    a_direct_addr: assert property (@(posedge clk) disable iff (sys_rst)
        dreq.f_addr != INDF_OFS |-> eff_addr == {bank_now, dreq.f_addr})
        else $error("direct address malformed");

    a_unimpl_zero: assert property (@(posedge clk) disable iff (sys_rst)
        dreq.rd && !is_ram && !is_sfr |=> rdata == 8'h00 && rvalid)
        else $error("unimplemented location read nonzero");

    a_read_valid: assert property (@(posedge clk) disable iff (sys_rst)
        dreq.rd && preq.step |=> rvalid)
        else $error("data read stalled by fetch");

    // ------------------------------------------------------------
    // further program side checks
    // ------------------------------------------------------------
    // jump takes the target low bits and latch bits above them
    a_jump_target: assert property (@(posedge clk) disable iff (sys_rst)
        preq.jump && !preq.irq && !dreq.wr |=>
            pc_r[10:0] == $past(preq.target) && pc_r[12:11] == pclath_r[4:3])
        else $error("jump target not loaded");

    a_irq_pcout: assert property (@(posedge clk) disable iff (sys_rst)
        preq.irq |=> pc_out == INT_VEC)
        else $error("counter output missed interrupt entry");

    // with no request the counter keeps its word
    a_pc_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !preq.step && !preq.jump && !preq.irq && !dreq.wr |=> $stable(pc_r))
        else $error("counter moved without request");

    // carry out of the implemented bits must not reach the fetch port
    a_wrap_carry: assert property (@(posedge clk) disable iff (sys_rst)
        preq.step && !preq.irq && !preq.jump && !dreq.wr && pc_r[10:0] == 11'h7ff |=>
            fetch_addr == 11'h000)
        else $error("fetch address did not wrap to zero");

    a_reset_fetch: assert property (@(posedge clk)
        $fell(sys_rst) |-> fetch_addr == 11'h000 && pc_out == RESET_VEC)
        else $error("fetch port not at zero after reset");

    // ------------------------------------------------------------
    // data side checks
    // ------------------------------------------------------------
    // pointer and state are written in every bank alike
    a_ptr_write: assert property (@(posedge clk) disable iff (sys_rst)
        dreq.wr && sfr_hit(eff_addr, PTR_OFS) |=> ptr_r == $past(dreq.wdata))
        else $error("pointer write lost");

    a_status_write: assert property (@(posedge clk) disable iff (sys_rst)
        dreq.wr && sfr_hit(eff_addr, STATUS_OFS) |=> status_r == $past(dreq.wdata))
        else $error("state write lost");

    // no read, no answer: the data port rests at zero
    a_rd_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !dreq.rd |=> !rvalid && rdata == 8'h00)
        else $error("read answer without read");

    a_read_ptr: assert property (@(posedge clk) disable iff (sys_rst)
        dreq.rd && sfr_hit(eff_addr, PTR_OFS) |=> rdata == $past(ptr_r))
        else $error("pointer read wrong");

    // a location is either a special register or ram, never both
    a_region_excl: assert property (@(posedge clk) disable iff (sys_rst)
        is_sfr |-> !is_ram)
        else $error("special register and ram overlap");

    a_bank0_ram: assert property (@(posedge clk) disable iff (sys_rst)
        !eff_addr[7] && eff_addr[6:0] >= GPR_LO |-> is_ram)
        else $error("even bank ram missing");

    // banked ram must stay clear of the shared top slots
    a_ram_banked: assert property (@(posedge clk) disable iff (sys_rst)
        is_ram && eff_addr[6:0] < SHARED_LO |-> ram_idx < SHARED_LO)
        else $error("banked ram hits shared slots");

    a_ram_shared: assert property (@(posedge clk) disable iff (sys_rst)
        eff_addr[6:0] >= SHARED_LO |-> is_ram && ram_idx[6:4] == 3'b111)
        else $error("shared area not in shared slots");

    // upper half of the odd banks, below the shared area, is a hole
    a_hole_zero: assert property (@(posedge clk) disable iff (sys_rst)
        dreq.rd && eff_addr[7] && eff_addr[6:0] >= 7'h40 && eff_addr[6:0] < SHARED_LO |=>
            rdata == 8'h00)
        else $error("hole in odd bank read nonzero");

    a_indirect_bank: assert property (@(posedge clk) disable iff (sys_rst)
        dreq.f_addr == INDF_OFS |-> eff_addr[8] == status_r[7])
        else $error("indirect access took wrong half");

endmodule : mmb_top

/* verif/mmb_top_tb.sv */
`timescale 1ns/1ps
module mmb_top_tb;
    import mmb_pkg::*;

    // ------------------------------------------------------------
    // design hookup
    // ------------------------------------------------------------
    logic clk;              // 50 MHz core clock
    logic sys_rst;          // async reset, active high
    mmb_preq_s preq;        // flow request
    mmb_dreq_s dreq;        // data request
    logic [12:0] pc_out;    // counter seen by the fetch side
    logic [10:0] fetch_addr; // implemented word address
    logic [7:0] rdata;      // read answer
    logic rvalid;           // read answer marker
    logic [1:0] bank_sel_field; // bank copy
    int n_fail;             // mismatches
    int checks;             // comparisons made
    logic [31:0] seed;      // xorshift state

    // ------------------------------------------------------------
    // reference model state
    // ------------------------------------------------------------
    logic [12:0] m_pc;      // expected counter
    logic [7:0] m_ptr;      // expected pointer
    logic [7:0] m_stat;     // expected state, only 7:5 compared
    logic [4:0] m_lath;     // expected counter high latch
    logic [7:0] m_ram [int]; // ram bytes known so far, lost at reset

    mmb_top #(.PROG_W(PROG_IMPL_W)) dut (
        .clk(clk), .sys_rst(sys_rst), .preq(preq), .dreq(dreq),
        .pc_out(pc_out), .fetch_addr(fetch_addr), .rdata(rdata),
        .rvalid(rvalid), .bank_sel_field(bank_sel_field));

    // free running clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // fixed seed so a failure can be replayed
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // location class of a 9-bit data address: ram key, or negative code
    // -1 reads zero, -2 pointer, -3 state, -4 latch, -5 counter low byte
    function automatic int loc(input logic [8:0] a);
        logic [6:0] o;
        o = a[6:0];
        if (o == 7'h02) return -5;
        if (o == 7'h03) return -3;
        if (o == 7'h04) return -2;
        if (o == 7'h0a) return -4;
        if (o >= 7'h70) return int'(o); // shared in all banks
        if (o >= 7'h20 && (!a[7] || o < 7'h40)) return int'({a[7], o});
        return -1; // unimplemented, includes the indirect slot itself
    endfunction : loc

    // one core cycle: drive, update model, compare after the edge
    task automatic go(input logic st, jp, iq, input logic [10:0] tg,
                      input logic rd, wr, input logic [6:0] fa, input logic [7:0] wd);
        logic [8:0] ea;
        int k;
        logic [7:0] er;
        logic [7:0] mk;
        logic ek;
        ea = (fa == 7'h00) ? {m_stat[7], m_ptr} : {m_stat[6:5], fa};
        k = loc(ea);
        // a counter-byte write would steer flow, kept out of the model
        if (k == -5) wr = 1'b0;
        preq = '{step: st, jump: jp, irq: iq, target: tg};
        dreq = '{rd: rd, wr: wr, f_addr: fa, wdata: wd};
        ek = 1'b1;
        er = 8'h00;
        mk = 8'hff;
        case (k)
            -5: ek = 1'b0;
            -3: begin er = m_stat; mk = 8'he0; end
            -2: er = m_ptr;
            -4: begin er = {3'h0, m_lath}; mk = 8'h1f; end
            -1: er = 8'h00;
            default: begin
                ek = m_ram.exists(k);
                if (ek) er = m_ram[k];
            end
        endcase
        // interrupt beats jump beats step
        if (iq) m_pc = INT_VEC;
        else if (jp) m_pc = {m_lath[4:3], tg};
        else if (st) m_pc = m_pc + 13'h1;
        if (wr) begin
            case (k)
                -3: m_stat[7:5] = wd[7:5];
                -2: m_ptr = wd;
                -4: m_lath = wd[4:0];
                -1: ;
                default: m_ram[k] = wd;
            endcase
        end
        @(posedge clk);
        #1;
        chk(pc_out, m_pc);
        chk(fetch_addr, m_pc[10:0]);
        chk(rvalid, rd);
        if (!rd) chk(rdata, 32'h0);
        else if (ek) chk(rdata & mk, er & mk);
        chk(bank_sel_field, m_stat[6:5]);
    endtask : go

    task automatic do_reset();
        sys_rst = 1'b1;
        preq = '0;
        dreq = '0;
        repeat (6) @(posedge clk);
        #1 sys_rst = 1'b0;
        m_pc = RESET_VEC;
        m_ptr = PTR_RST;
        m_stat = STATUS_RST;
        m_lath = PCLATH_RST;
        m_ram.delete();
        chk(pc_out, 32'h0);
        chk(fetch_addr, 32'h0);
        chk(bank_sel_field, 32'h0);
    endtask : do_reset

    task automatic give_verdict();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int i;
        logic [31:0] r;
        logic [31:0] r2;
        sys_rst = 1'b1;
        preq = '0;
        dreq = '0;
        n_fail = 0;
        checks = 0;
        seed = 32'd19659;
        do_reset();
        // latch high bits 01, jump near the top of the second 2K page
        go(0, 0, 0, 11'h0, 0, 1, PCLATH_OFS, 8'h08);
        go(0, 1, 0, 11'h7fe, 0, 0, 7'h0, 8'h0);
        go(1, 0, 0, 11'h0, 0, 0, 7'h0, 8'h0);
        go(1, 0, 0, 11'h0, 0, 0, 7'h0, 8'h0);
        go(1, 1, 1, 11'h123, 0, 0, 7'h0, 8'h0);
        // every bank: ram, aliasing, shared area, holes, pointer path
        for (i = 0; i < 4; i++) begin
            go(0, 0, 0, 11'h0, 0, 1, STATUS_OFS, {1'b0, i[1:0], 5'h00});
            go(0, 0, 0, 11'h0, 1, 1, 7'h25, 8'ha0 + i[7:0]);
            go(0, 0, 0, 11'h0, 1, 1, 7'h75, 8'h50 + i[7:0]);
            go(0, 0, 0, 11'h0, 1, 0, 7'h25, 8'h0);
            go(0, 0, 0, 11'h0, 1, 0, 7'h45, 8'h0);
            go(0, 0, 0, 11'h0, 1, 0, 7'h05, 8'h0);
            go(0, 0, 0, 11'h0, 0, 1, PTR_OFS, 8'h25 + {i[1:0], 6'h0});
            go(0, 0, 0, 11'h0, 1, 0, INDF_OFS, 8'h0);
        end
        go(0, 0, 0, 11'h0, 0, 1, PTR_OFS, 8'h80);
        go(0, 0, 0, 11'h0, 1, 0, INDF_OFS, 8'h0);
        // random traffic on both ports with one reset in mid-run
        for (i = 0; i < 3000; i++) begin
            r = rnd();
            r2 = rnd();
            if (i == 1500) do_reset();
            go(r[0], r[3:1] == 3'h0, r[8:4] == 5'h0, r[19:9], r[20], r[21],
               r[22] ? r[29:23] : {3'h0, r[26:23]}, r2[7:0]);
        end
        give_verdict();
    end

endmodule : mmb_top_tb
